/* inc/hall_motor_pkg.sv */
// constants and types shared by the hall sine motor commutator
package hall_motor_pkg;
  // ***************************************************************
  // clock and timing
  // ***************************************************************
  localparam int CLK_HZ = 100_000_000;
  localparam int PRECHG_MS = 9;
  localparam int PRECHG_CYC = PRECHG_MS * (CLK_HZ / 1000);
  localparam int LOCK_S = 6;
  localparam int LOCK_CYC = LOCK_S * CLK_HZ;
  localparam int HALL_MIN_HZ = 1;
  localparam int SECTORS = 6;
  localparam int GAP_CYC = CLK_HZ / (HALL_MIN_HZ * SECTORS);
  localparam logic [1:0] SETTLE_LAST = 2'h3;
  // ***************************************************************
  // converter codes, 7-bit, speed full scale 10 V, advance 5 V
  // ***************************************************************
  localparam logic [6:0] SPD_LOW = 7'h0d;
  localparam logic [6:0] SPD_MID = 7'h1b;
  localparam logic [6:0] SPD_UP = 7'h45;
  localparam logic [6:0] SPD_TEST = 7'h67;
  localparam logic [6:0] ADV_TEST_LO = 7'h44;
  localparam logic [6:0] ADV_TEST_HI = 7'h48;
  localparam logic [16:0] DUTY_SCALE = 17'h00306;
  localparam int DUTY_SHIFT = 8;
  // ***************************************************************
  // pwm and sector counts
  // ***************************************************************
  localparam logic [6:0] PWM_TOP = 7'h7e;
  localparam logic [6:0] PWM_FULL = 7'h7f;
  localparam logic [6:0] CHG_ON = 7'h40;
  localparam logic [4:0] EDGES_PER_STEP = 5'h18;
  localparam logic [2:0] SECT_NONE = 3'h7;
  localparam logic [2:0] SECT_LAST = 3'h5;
  // ***************************************************************
  // register map
  // ***************************************************************
  localparam int ADDR_W = 4;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [5:0] {
    ST_START = 6'h01,
    ST_OFF = 6'h02,
    ST_CHG = 6'h04,
    ST_PRE = 6'h08,
    ST_RUN = 6'h10,
    ST_LOCK = 6'h20
  } mode_t;
endpackage

/* rtl/hall_sine_motor_commutator.sv */
// hall sine motor commutator: startup, commutation, pwm, lock, regs
`timescale 1ns/10ps
module hall_sine_motor_commutator #(
  parameter int PRECHG = hall_motor_pkg::PRECHG_CYC,
  parameter int LOCKT = hall_motor_pkg::LOCK_CYC,
  parameter int GAP = hall_motor_pkg::GAP_CYC
) (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clkEn,
  // pins from hall sensors and setting straps
  input wire logic hallPosU,
  input wire logic hallPosV,
  input wire logic hallPosW,
  input wire logic directionSelect,
  input wire logic lockProtectSelect,
  // converter codes on this clock
  input wire logic [6:0] speedCode,
  input wire logic [6:0] advanceCode,
  // bridge drives, bit 2 U, bit 1 V, bit 0 W
  output logic [2:0] highSideOn,
  output logic [2:0] lowSideOn,
  output logic sineMode,
  output logic lockActive,
  output logic testMode,
  output logic [5:0] advanceAngle,
  // axi4-lite slave
  input wire logic [3:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  typedef struct packed {
    hall_motor_pkg::mode_t st;
    logic [1:0] settle;
    logic [4:0] s1, s2, s3, pin;
    logic lockEn, test, dir, sine, fast, rev, enable;
    logic [2:0] hPrev, hiOn, loOn;
    logic [6:0] pwm;
    logic [29:0] tmr;
    logic [24:0] gap;
    logic [4:0] edges;
    logic [5:0] angle;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
  } state_t;

  localparam state_t RST = '{st: hall_motor_pkg::ST_START,
    gap: '1, enable: hall_motor_pkg::CTRL_EN_RST, default: '0};

  state_t q, d;
  logic [2:0] hall, pat, sN, sP, cHi, cLo, pHi, pLo;
  logic moveBack, moveAhead;
  logic [6:0] duty;
  logic [16:0] prod;
  logic hallEdge, lockClear, gate;

  // forward sector order, pattern 101 is sector 0
  function automatic logic [2:0] sectOf(input logic [2:0] p);
    case (p)
      3'b101: sectOf = 3'h0;
      3'b100: sectOf = 3'h1;
      3'b110: sectOf = 3'h2;
      3'b010: sectOf = 3'h3;
      3'b011: sectOf = 3'h4;
      3'b001: sectOf = 3'h5;
      default: sectOf = hall_motor_pkg::SECT_NONE;
    endcase
  endfunction

  // {high U V W, low U V W}; reverse uses the inverted pattern
  function automatic logic [5:0] commute(input logic [2:0] p);
    case (p)
      3'b101: commute = 6'b010_100;
      3'b100: commute = 6'b001_100;
      3'b110: commute = 6'b001_010;
      3'b010: commute = 6'b100_010;
      3'b011: commute = 6'b100_001;
      3'b001: commute = 6'b010_001;
      default: commute = 6'b000_000;
    endcase
  endfunction

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb begin
    d = q;
    lockClear = 1'b0;
    d.s1 = {lockProtectSelect, directionSelect,
            hallPosU, hallPosV, hallPosW};
    d.s2 = q.s1;
    d.s3 = q.s2;
    // a pin change counts once second and third stage agree
    d.pin = (q.s3 & ~(q.s2 ^ q.s3)) | (q.pin & (q.s2 ^ q.s3));
    hall = q.pin[2:0];
    pat = q.dir ? hall : ~hall;
    sN = sectOf(hall);
    sP = sectOf(q.hPrev);
    hallEdge = hall != q.hPrev;
    d.hPrev = hall;
    d.pwm = (q.pwm == hall_motor_pkg::PWM_TOP) ? 7'h00 : q.pwm + 7'h01;
    // linear map keeps the shaping in one multiply
    prod = 17'(speedCode - hall_motor_pkg::SPD_MID)
           * hall_motor_pkg::DUTY_SCALE;
    if (speedCode >= hall_motor_pkg::SPD_UP) begin
      duty = hall_motor_pkg::PWM_FULL;
    end else if (speedCode < hall_motor_pkg::SPD_MID) begin
      duty = 7'h00;
    end else begin
      duty = prod[hall_motor_pkg::DUTY_SHIFT +: 7];
    end
    gate = q.pwm < duty;
    // sector timing: saturating gap avoids a false fast on first edge
    if (hallEdge) begin
      d.gap = '0;
      d.fast = q.gap < 25'(GAP);
    end else if (q.gap < 25'(GAP)) begin
      d.gap = q.gap + 25'h1;
    end else begin
      d.fast = 1'b0;
    end
    moveBack = (sP == 3'h0) ? (sN == hall_motor_pkg::SECT_LAST)
               : (sN == sP - 3'h1);
    moveAhead = (sP == hall_motor_pkg::SECT_LAST) ? (sN == 3'h0)
                : (sN == sP + 3'h1);
    if (hallEdge && sN != hall_motor_pkg::SECT_NONE
        && sP != hall_motor_pkg::SECT_NONE) begin
      // inverting the code only rotates the sector index, so the
      // wrong-way test has to flip with the direction setting
      d.rev = q.dir ? moveBack : moveAhead;
    end
    if (q.st != hall_motor_pkg::ST_START) begin
      d.dir = q.pin[3];
    end
    // phase advance stepping
    if (hallEdge) begin
      d.edges = (q.edges == hall_motor_pkg::EDGES_PER_STEP - 5'h1)
                ? 5'h00 : q.edges + 5'h01;
    end
    if (q.test) begin
      d.angle = 6'h00;
    end else if (hallEdge
        && q.edges == hall_motor_pkg::EDGES_PER_STEP - 5'h1) begin
      if (q.angle < advanceCode[6:1]) begin
        d.angle = q.angle + 6'h01;
      end else if (q.angle > advanceCode[6:1]) begin
        d.angle = q.angle - 6'h01;
      end
    end
    // ***************************************************************
    // register bus
    // ***************************************************************
    d.awready = 1'b0;
    d.wready = 1'b0;
    d.arready = 1'b0;
    if (awvalid && wvalid && !q.awready && !q.bvalid) begin
      d.awready = 1'b1;
      d.wready = 1'b1;
      d.bresp = hall_motor_pkg::RESP_SLVERR;
      if (awaddr == hall_motor_pkg::REG_CTRL) begin
        d.bresp = hall_motor_pkg::RESP_OKAY;
        if (wstrb[0]) begin
          d.enable = wdata[0];
          lockClear = wdata[1];
        end
      end else if (awaddr == hall_motor_pkg::REG_STATUS) begin
        d.bresp = hall_motor_pkg::RESP_OKAY;
      end
    end
    if (q.awready) begin
      d.bvalid = 1'b1;
    end else if (q.bvalid && bready) begin
      d.bvalid = 1'b0;
    end
    if (arvalid && !q.arready && !q.rvalid) begin
      d.arready = 1'b1;
      d.rresp = hall_motor_pkg::RESP_OKAY;
      d.rdata = '0;
      if (araddr == hall_motor_pkg::REG_CTRL) begin
        d.rdata = 32'(q.enable);
      end else if (araddr == hall_motor_pkg::REG_STATUS) begin
        d.rdata = 32'({q.angle, duty, q.st, q.test, q.lockEn,
                       q.dir, q.rev, q.fast, q.sine});
      end else begin
        d.rresp = hall_motor_pkg::RESP_SLVERR;
      end
    end
    if (q.arready) begin
      d.rvalid = 1'b1;
    end else if (q.rvalid && rready) begin
      d.rvalid = 1'b0;
    end
    // ***************************************************************
    // sequencer
    // ***************************************************************
    {cHi, cLo} = commute(pat);
    pHi = 3'b000;
    pLo = 3'b000;
    case (q.st)
      hall_motor_pkg::ST_START: begin
        d.settle = q.settle + 2'h1;
        if (q.settle == hall_motor_pkg::SETTLE_LAST) begin
          // the filtered pin is only settled in its next value here
          d.lockEn = !d.pin[4];
          d.dir = d.pin[3];
          d.test = speedCode >= hall_motor_pkg::SPD_TEST
                   && advanceCode >= hall_motor_pkg::ADV_TEST_LO
                   && advanceCode <= hall_motor_pkg::ADV_TEST_HI;
          d.st = hall_motor_pkg::ST_OFF;
        end
      end
      hall_motor_pkg::ST_OFF: begin
        d.tmr = '0;
        if (q.enable && speedCode >= hall_motor_pkg::SPD_MID) begin
          d.st = hall_motor_pkg::ST_PRE;
        end else if (q.enable && speedCode >= hall_motor_pkg::SPD_LOW) begin
          d.st = hall_motor_pkg::ST_CHG;
        end
      end
      hall_motor_pkg::ST_CHG: begin
        d.tmr = '0;
        if (!q.fast && !q.rev && q.pwm < hall_motor_pkg::CHG_ON) begin
          pLo = 3'b111;
        end
        if (speedCode >= hall_motor_pkg::SPD_MID) begin
          d.st = hall_motor_pkg::ST_RUN;
        end
      end
      hall_motor_pkg::ST_PRE: begin
        d.tmr = q.tmr + 30'h1;
        if (q.pwm < hall_motor_pkg::CHG_ON) begin
          pLo = 3'b111;
        end
        if (q.tmr == 30'(PRECHG - 1)) begin
          d.tmr = '0;
          d.st = hall_motor_pkg::ST_RUN;
        end
      end
      hall_motor_pkg::ST_RUN: begin
        d.tmr = hallEdge ? 30'h0 : q.tmr + 30'h1;
        pLo = cLo;
        // test mode holds high sides on in trapezoid drive only
        pHi = cHi & {3{gate || (q.test && !q.sine)}};
        if (q.lockEn && !hallEdge && q.tmr == 30'(LOCKT - 1)) begin
          d.st = hall_motor_pkg::ST_LOCK;
          pHi = 3'b000;
          pLo = 3'b000;
        end
      end
      hall_motor_pkg::ST_LOCK: begin
        if (lockClear) begin
          d.st = hall_motor_pkg::ST_OFF;
        end
      end
      default: d.st = hall_motor_pkg::ST_START;
    endcase
    if (q.st != hall_motor_pkg::ST_START
        && (!q.enable || speedCode < hall_motor_pkg::SPD_LOW)) begin
      pHi = 3'b000;
      pLo = 3'b000;
      if (q.st != hall_motor_pkg::ST_LOCK) begin
        d.st = hall_motor_pkg::ST_OFF;
      end
    end
    d.sine = q.st == hall_motor_pkg::ST_RUN && q.fast && !q.rev;
    d.hiOn = pHi;
    d.loOn = pLo;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      q <= RST;
    end else if (clkEn) begin
      q <= d;
    end
  end

  assign highSideOn = q.hiOn;
  assign lowSideOn = q.loOn;
  assign sineMode = q.sine;
  assign lockActive = q.st == hall_motor_pkg::ST_LOCK;
  assign testMode = q.test;
  assign advanceAngle = q.angle;
  assign {awready, wready, bvalid, bresp} = {q.awready, q.wready,
                                             q.bvalid, q.bresp};
  assign {arready, rvalid, rresp, rdata} = {q.arready, q.rvalid,
                                            q.rresp, q.rdata};

  // ***************************************************************
  // checks
  // ***************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn || !clkEn);
  sequence preDone;
    q.st == hall_motor_pkg::ST_PRE ##1 q.st == hall_motor_pkg::ST_RUN;
  endsequence
  AST_OFF_LOW: assert property (q.st != hall_motor_pkg::ST_START
    && speedCode < hall_motor_pkg::SPD_LOW |=> highSideOn == 3'b000
    && lowSideOn == 3'b000) else $error("drive on below low code");
  AST_PRECHG: assert property (preDone |->
    $past(q.tmr) == 30'(PRECHG - 1)) else $error("precharge length");
  AST_FWD: assert property (q.st == hall_motor_pkg::ST_RUN
    && q.dir && hall == 3'b101 && speedCode >= hall_motor_pkg::SPD_UP
    && q.enable |=> lowSideOn == 3'b100 && highSideOn == 3'b010)
    else $error("forward table");
  AST_REV: assert property (q.st == hall_motor_pkg::ST_RUN
    && !q.dir && hall == 3'b010 && speedCode >= hall_motor_pkg::SPD_UP
    && q.enable |=> lowSideOn == 3'b100 && highSideOn == 3'b010)
    else $error("reverse table");
  AST_CHARGE: assert property (q.st == hall_motor_pkg::ST_CHG
    && q.enable && speedCode >= hall_motor_pkg::SPD_LOW && !q.fast
    && !q.rev && q.pwm < hall_motor_pkg::CHG_ON |=> lowSideOn == 3'b111)
    else $error("no charge");
  AST_STEP: assert property (!q.test && advanceAngle != $past(advanceAngle)
    |-> advanceAngle - $past(advanceAngle) == 6'h01
    || $past(advanceAngle) - advanceAngle == 6'h01)
    else $error("angle step size");
  AST_TEST0: assert property (q.test |=> advanceAngle == 6'h00)
    else $error("test angle not zero");
  AST_REVTRAP: assert property (q.rev |=> !sineMode)
    else $error("sine during reverse");
  AST_BAD_HALL: assert property ((hall == 3'b000 || hall == 3'b111)
    |=> highSideOn == 3'b000) else $error("drive on invalid hall");
endmodule // hall_sine_motor_commutator

/* dv/hall_motor_model.sv */
// partner model: motor whose hall sensors step one sector per request
`timescale 1ns/10ps
module hall_motor_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // step requests from the bench
  input wire logic stepFwd,
  input wire logic stepRev,
  input wire logic badHall,
  // hall sensor pins
  output logic hallPosU,
  output logic hallPosV,
  output logic hallPosW
);
  logic [2:0] sector_q;
  logic [2:0] pat;
  // ********
  // hall code in forward rotation order
  // ********
  always_comb begin
    case (sector_q)
      3'h0: pat = 3'h5;
      3'h1: pat = 3'h4;
      3'h2: pat = 3'h6;
      3'h3: pat = 3'h2;
      3'h4: pat = 3'h3;
      default: pat = 3'h1;
    endcase
  end
  // a broken sensor harness reads all high
  assign {hallPosU, hallPosV, hallPosW} = badHall ? 3'h7 : pat;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sector_q <= 3'h0;
    end else if (stepFwd) begin
      sector_q <= (sector_q == 3'h5) ? 3'h0 : sector_q + 3'h1;
    end else if (stepRev) begin
      sector_q <= (sector_q == 3'h0) ? 3'h5 : sector_q - 3'h1;
    end
  end
endmodule // hall_motor_model

/* dv/test_hall_sine_motor_commutator.sv */
// self-checking bench for the hall sine motor commutator
`timescale 1ns/10ps
module test_hall_sine_motor_commutator;
  // ********
  // signals
  // ********
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic fwd = 1'b0, rev = 1'b0, bad = 1'b0;
  logic dirSel = 1'b1, lockSel = 1'b0;
  logic [6:0] spd = 7'h00, adv = 7'h00;
  logic hu, hv, hw, sine, lockAct, testM;
  logic [2:0] hi, lo;
  logic [5:0] ang, a0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  int n_fail = 0, samples_checked = 0;
  int hc, lc, i;

  hall_motor_model bridge (.clk_sys(clk_sys), .resetn(resetn),
    .stepFwd(fwd), .stepRev(rev), .badHall(bad),
    .hallPosU(hu), .hallPosV(hv), .hallPosW(hw));
  hall_sine_motor_commutator #(.PRECHG(50), .LOCKT(300), .GAP(200)) dut (
    .clk_sys(clk_sys), .resetn(resetn), .clkEn(1'b1),
    .hallPosU(hu), .hallPosV(hv), .hallPosW(hw),
    .directionSelect(dirSel), .lockProtectSelect(lockSel),
    .speedCode(spd), .advanceCode(adv),
    .highSideOn(hi), .lowSideOn(lo), .sineMode(sine),
    .lockActive(lockAct), .testMode(testM), .advanceAngle(ang),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  // ********
  // tasks
  // ********
  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %0t: got %h want %h", $time, g, e);
    end
  endtask
  task axw(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(negedge clk_sys); while (awready !== 1'b1);
    @(posedge clk_sys);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(negedge clk_sys); while (bvalid !== 1'b1);
    rs = bresp;
    @(posedge clk_sys);
    bready <= 1'b0;
  endtask
  task axr(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge clk_sys); while (arready !== 1'b1);
    @(posedge clk_sys);
    arvalid <= 1'b0;
    do @(negedge clk_sys); while (rvalid !== 1'b1);
    v = rdata;
    rs = rresp;
    @(posedge clk_sys);
    rready <= 1'b0;
  endtask
  task step(input logic back, input int gap);
    @(posedge clk_sys);
    fwd <= !back;
    rev <= back;
    @(posedge clk_sys);
    fwd <= 1'b0;
    rev <= 1'b0;
    cyc(gap);
  endtask
  // counts cycles with any high side on and with all low sides on
  task meas(input int n);
    hc = 0;
    lc = 0;
    repeat (n) begin
      @(negedge clk_sys);
      if (hi !== 3'h0) hc++;
      if (lo === 3'h7) lc++;
    end
    @(posedge clk_sys);
  endtask
  function automatic logic [5:0] tbl(input logic [2:0] h);
    case (h)
      3'h5: return 6'h14;
      3'h4: return 6'h0c;
      3'h6: return 6'h0a;
      3'h2: return 6'h22;
      3'h3: return 6'h21;
      3'h1: return 6'h11;
      default: return 6'h00;
    endcase
  endfunction
  // reverse drive of a code equals forward drive of its complement
  task hcheck;
    @(negedge clk_sys);
    chk({hi, lo}, tbl(dirSel ? {hu, hv, hw} : ~{hu, hv, hw}));
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ********
  // tests
  // ********
  initial begin
    cyc(3);
    resetn <= 1'b1;
    cyc(8);
    axr(hall_motor_pkg::REG_CTRL, d, r);
    chk(d, 32'h1);
    axr(hall_motor_pkg::REG_STATUS, d, r);
    chk({20'h0, d[11:0]}, 32'h98);
    meas(127);
    chk(hc + lc, 0);
    $display("test idle done");
    spd <= 7'h45;
    cyc(10);
    axr(hall_motor_pkg::REG_STATUS, d, r);
    chk(d[11:6], 6'h08);
    meas(28);
    chk(hc, 0);
    cyc(20);
    axr(hall_motor_pkg::REG_STATUS, d, r);
    chk(d[11:6], 6'h10);
    $display("test precharge done");
    for (i = 0; i < 6; i++) begin
      step(1'b0, 210);
      hcheck();
      chk(sine, 1'h0);
    end
    step(1'b0, 4);
    meas(127);
    chk(hc, 127);
    @(posedge clk_sys);
    spd <= 7'h30;
    cyc(4);
    meas(127);
    chk(hc, 63);
    axr(hall_motor_pkg::REG_STATUS, d, r);
    chk(d[18:12], 7'h3f);
    $display("test commutation done");
    step(1'b0, 250);
    chk(lockAct, 1'h0);
    i = 0;
    while (lockAct !== 1'b1 && i < 100) begin
      @(negedge clk_sys);
      i++;
    end
    chk(lockAct, 1'h1);
    chk({hi, lo}, 6'h00);
    @(posedge clk_sys);
    spd <= 7'h00;
    axw(hall_motor_pkg::REG_CTRL, 32'h3, r);
    cyc(5);
    axr(hall_motor_pkg::REG_STATUS, d, r);
    chk(d[11:6], 6'h02);
    $display("test lock done");
    spd <= 7'h10;
    cyc(5);
    axr(hall_motor_pkg::REG_STATUS, d, r);
    chk(d[11:6], 6'h04);
    meas(127);
    chk(lc, 64);
    chk(hc, 0);
    repeat (8) step(1'b0, 20);
    meas(127);
    chk(lc, 0);
    $display("test charging done");
    spd <= 7'h45;
    adv <= 7'h7e;
    repeat (30) step(1'b0, 20);
    chk(sine, 1'h1);
    a0 = ang;
    repeat (24) step(1'b0, 20);
    chk(ang, a0 + 6'h1);
    bad <= 1'b1;
    cyc(8);
    @(negedge clk_sys);
    chk({hi, lo}, 6'h00);
    @(posedge clk_sys);
    bad <= 1'b0;
    step(1'b0, 20);
    chk(sine, 1'h1);
    step(1'b1, 8);
    chk(sine, 1'h0);
    $display("test sine done");
    dirSel <= 1'b0;
    for (i = 0; i < 6; i++) begin
      step(1'b1, 210);
      hcheck();
    end
    $display("test reverse done");
    axr(4'h8, d, r);
    chk(r, hall_motor_pkg::RESP_SLVERR);
    chk(d, 32'h0);
    axw(4'hc, 32'h0, r);
    chk(r, hall_motor_pkg::RESP_SLVERR);
    $display("test bus done");
    @(posedge clk_sys);
    resetn <= 1'b0;
    spd <= 7'h70;
    adv <= 7'h46;
    cyc(3);
    resetn <= 1'b1;
    cyc(12);
    chk(testM, 1'h1);
    chk(ang, 6'h00);
    $display("test testmode done");
    wrap_up();
  end
  // hangs are cut short well beyond the expected run of some 5000 cycles
  initial begin
    cyc(50000);
    n_fail++;
    $display("ERROR %0t: timeout", $time);
    wrap_up();
  end
endmodule // test_hall_sine_motor_commutator
